// [src/greater_equal_compare_unit.sv]
`timescale 1ns/10ps
`include "ge_compare_map.svh"

module greater_equal_compare_unit (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_valid,
    input wire logic [`WORD_W-1:0] i_instr,
    input wire logic [`WORD_W-1:0] i_first_operand,
    input wire logic [`WORD_W-1:0] i_second_operand,
    output logic o_accept,
    output logic o_result_valid,
    output logic [`WORD_W-1:0] o_result,
    output logic [`INDEX_W-1:0] o_dest_index,
    output logic o_exception
);

    // ************************************************
    // Field helpers
    // ************************************************

    function automatic logic [`OP_W-1:0] op_field(input logic [`WORD_W-1:0] instr);
        op_field = instr[`OP_HI:`OP_LO];
    endfunction

    function automatic logic [`OP_W-1:0] xop_field(input logic [`WORD_W-1:0] instr);
        xop_field = instr[`XOP_HI:`XOP_LO];
    endfunction

    function automatic logic [`INDEX_W-1:0] pad_field(input logic [`WORD_W-1:0] instr);
        pad_field = instr[`PAD_HI:`PAD_LO];
    endfunction

    function automatic logic [`IMM_W-1:0] imm_field(input logic [`WORD_W-1:0] instr);
        imm_field = instr[`IMM_HI:`IMM_LO];
    endfunction

    function automatic logic [`WORD_W-1:0] sign_extend(input logic [`IMM_W-1:0] imm);
        sign_extend = {{(`WORD_W-`IMM_W){imm[`IMM_W-1]}}, imm};
    endfunction

    function automatic logic [`WORD_W-1:0] zero_extend(input logic [`IMM_W-1:0] imm);
        zero_extend = {{(`WORD_W-`IMM_W){1'b0}}, imm};
    endfunction

    // Only bit 0 carries the outcome
    function automatic logic [`WORD_W-1:0] result_word(input logic ge_bit);
        result_word = {{(`WORD_W-1){1'b0}}, ge_bit};
    endfunction

    // ************************************************
    // Decode functions
    // ************************************************

    function automatic logic is_signed_imm(input logic [`WORD_W-1:0] instr);
        is_signed_imm = (op_field(instr) == `OP_GE_SIGNED_IMM);
    endfunction

    function automatic logic is_unsigned_imm(input logic [`WORD_W-1:0] instr);
        is_unsigned_imm = (op_field(instr) == `OP_GE_UNSIGNED_IMM);
    endfunction

    // Register form also needs the extended opcode and a zero pad
    function automatic logic is_unsigned_reg(input logic [`WORD_W-1:0] instr);
        is_unsigned_reg = (op_field(instr) == `OP_REG_TYPE) &&
                          (xop_field(instr) == `XOP_GE_UNSIGNED) &&
                          (pad_field(instr) == `PAD_ZERO);
    endfunction

    function automatic ge_compare_pkg::form_t decode_form(input logic [`WORD_W-1:0] instr);
        decode_form = ge_compare_pkg::FORM_NONE;
        if (is_signed_imm(instr)) begin
            decode_form = ge_compare_pkg::FORM_GE_SIGNED_IMM;
        end else if (is_unsigned_imm(instr)) begin
            decode_form = ge_compare_pkg::FORM_GE_UNSIGNED_IMM;
        end else if (is_unsigned_reg(instr)) begin
            decode_form = ge_compare_pkg::FORM_GE_UNSIGNED_REG;
        end
    endfunction

    function automatic logic is_compare(input ge_compare_pkg::form_t form);
        is_compare = (form != ge_compare_pkg::FORM_NONE);
    endfunction

    function automatic logic [`INDEX_W-1:0] dest_of(input logic [`WORD_W-1:0] instr,
                                                    input ge_compare_pkg::form_t form);
        if (form == ge_compare_pkg::FORM_GE_UNSIGNED_REG) begin
            dest_of = instr[`THIRD_HI:`THIRD_LO];
        end else begin
            dest_of = instr[`SECOND_HI:`SECOND_LO];
        end
    endfunction

    // ************************************************
    // Field extraction
    // ************************************************

    ge_compare_pkg::form_t form;
    logic [`IMM_W-1:0] immediate_field;
    logic [`INDEX_W-1:0] third_register;
    logic [`WORD_W-1:0] imm_signed_ext;
    logic [`WORD_W-1:0] imm_zero_ext;

    always_comb begin
        form = decode_form(i_instr);
        immediate_field = imm_field(i_instr);
        third_register = dest_of(i_instr, form);
        imm_signed_ext = sign_extend(immediate_field);
        imm_zero_ext = zero_extend(immediate_field);
    end

    // ************************************************
    // Operand selection
    // ************************************************

    logic [`WORD_W-1:0] rhs;
    logic use_signed;

    always_comb begin
        rhs = i_second_operand;
        use_signed = 1'b0;
        unique case (form)
            ge_compare_pkg::FORM_GE_SIGNED_IMM: begin
                rhs = imm_signed_ext;
                use_signed = 1'b1;
            end
            ge_compare_pkg::FORM_GE_UNSIGNED_IMM: begin
                rhs = imm_zero_ext;
                use_signed = 1'b0;
            end
            ge_compare_pkg::FORM_GE_UNSIGNED_REG: begin
                rhs = i_second_operand;
                use_signed = 1'b0;
            end
            ge_compare_pkg::FORM_NONE: begin
                rhs = i_second_operand;
                use_signed = 1'b0;
            end
        endcase
    end

    // ************************************************
    // Comparator
    // ************************************************

    logic ge;

    ge_compare u_ge_compare (
        .i_lhs(i_first_operand),
        .i_rhs(rhs),
        .i_signed(use_signed),
        .o_ge(ge)
    );

    // ************************************************
    // Handshake
    // ************************************************

    // Instruction is taken only when it is one of the three forms
    always_comb begin
        o_accept = i_valid && is_compare(form);
    end

    // ************************************************
    // Result stage
    // ************************************************

    logic result_valid;
    logic next_result_valid;

    // Valid pulses once per accepted instruction
    always_comb begin
        next_result_valid = o_accept;
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            result_valid <= 1'b0;
        end else begin
            result_valid <= next_result_valid;
        end
    end

    logic [`WORD_W-1:0] result;
    logic [`INDEX_W-1:0] dest_index;
    logic [`WORD_W-1:0] next_result;
    logic [`INDEX_W-1:0] next_dest_index;

    // Data hold their last value between accepted instructions
    always_comb begin
        next_result = result;
        next_dest_index = dest_index;
        if (o_accept) begin
            next_result = result_word(ge);
            next_dest_index = third_register;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            result <= `RESULT_RESET;
            dest_index <= `INDEX_RESET;
        end else begin
            result <= next_result;
            dest_index <= next_dest_index;
        end
    end

    // ************************************************
    // Outputs
    // ************************************************

    always_comb begin
        o_result_valid = result_valid;
        o_result = result;
        o_dest_index = dest_index;
        o_exception = 1'b0;
    end

endmodule

// [src/ge_compare_map.svh]
`ifndef GE_COMPARE_MAP_SVH
`define GE_COMPARE_MAP_SVH
// How it works
// - Signed immediate form sign-extends its 16-bit immediate to 32 bits.
// - Signed immediate form writes 1 if operand >= immediate (signed), else 0.
// - Signed immediate form: A 31:27, B 26:22, immediate 21:6, opcode 08.
// - Unsigned register form writes 1 if A >= B unsigned, else 0.
// - Register form: A, B, C 21:17, extended opcode 28, zeros 10:6, opcode 3a.
// - Unsigned immediate form zero-extends its 16-bit immediate to 32 bits.
// - Unsigned immediate form writes 1 if operand >= immediate (unsigned), else 0.
// - Unsigned immediate form is immediate-type with unsigned 16-bit immediate field.

// Word and field widths
`define WORD_W 32
`define INDEX_W 5
`define IMM_W 16
`define OP_W 6

// Field positions
`define FIRST_HI 31
`define FIRST_LO 27
`define SECOND_HI 26
`define SECOND_LO 22
`define THIRD_HI 21
`define THIRD_LO 17
`define IMM_HI 21
`define IMM_LO 6
`define XOP_HI 16
`define XOP_LO 11
`define PAD_HI 10
`define PAD_LO 6
`define OP_HI 5
`define OP_LO 0

// Encodings
`define OP_GE_SIGNED_IMM 6'h08
`define OP_GE_UNSIGNED_IMM 6'h28
`define OP_REG_TYPE 6'h3a
`define XOP_GE_UNSIGNED 6'h28
`define PAD_ZERO 5'h00

// Reset values
`define RESULT_RESET 32'h0000_0000
`define INDEX_RESET 5'h00
`endif

// [src/ge_compare_pkg.sv]
package ge_compare_pkg;
    // Which compare form an instruction word holds
    typedef enum logic [1:0] {
        FORM_NONE = 2'h0,
        FORM_GE_SIGNED_IMM = 2'h1,
        FORM_GE_UNSIGNED_REG = 2'h3,
        FORM_GE_UNSIGNED_IMM = 2'h2
    } form_t;
endpackage

// [src/ge_compare.sv]
`timescale 1ns/10ps
`include "ge_compare_map.svh"

module ge_compare (
    input wire logic [`WORD_W-1:0] i_lhs,
    input wire logic [`WORD_W-1:0] i_rhs,
    input wire logic i_signed,
    output logic o_ge
);
    logic [`WORD_W:0] lhs_ext;
    logic [`WORD_W:0] rhs_ext;
    logic [`WORD_W:0] diff;

    // Extra top bit carries sign or zero, one subtractor serves both
    always_comb begin
        lhs_ext = {i_signed & i_lhs[`WORD_W-1], i_lhs};
        rhs_ext = {i_signed & i_rhs[`WORD_W-1], i_rhs};
        diff = lhs_ext - rhs_ext;
        o_ge = ~diff[`WORD_W];
    end
endmodule

// [tb/ge_unit_checker.sv]
`timescale 1ns/10ps
module ge_unit_checker (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_valid,
    input wire logic [31:0] i_instr,
    input wire logic [31:0] i_first_operand,
    input wire logic [31:0] i_second_operand,
    input wire logic o_accept,
    input wire logic o_result_valid,
    input wire logic [31:0] o_result,
    input wire logic [4:0] o_dest_index,
    input wire logic o_exception
);
    wire [5:0] op = i_instr[5:0];
    wire tk = i_valid && o_accept;
    wire ges = $signed(i_first_operand) >= $signed({{16{i_instr[21]}}, i_instr[21:6]});
    wire geu = i_first_operand >= {16'h0, i_instr[21:6]};
    wire ger = i_first_operand >= i_second_operand;
    wire fit = op == 6'h08 || op == 6'h28 || (op == 6'h3a && i_instr[16:6] == 11'h500);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    property p_dec; o_accept == (i_valid && fit); endproperty
    a_dec: assert property (p_dec) else $error("decode");
    property p_sgn; tk && op == 6'h08 |=> o_result == {31'h0, $past(ges)}; endproperty
    a_sgn: assert property (p_sgn) else $error("signed imm");
    property p_uim; tk && op == 6'h28 |=> o_result == {31'h0, $past(geu)}; endproperty
    a_uim: assert property (p_uim) else $error("unsigned imm");
    property p_reg; tk && op == 6'h3a |=> o_result == {31'h0, $past(ger)}; endproperty
    a_reg: assert property (p_reg) else $error("register form");
    property p_rv; o_result_valid |-> $past(tk); endproperty
    a_rv: assert property (p_rv) else $error("valid");
    property p_exc; o_exception == 1'h0; endproperty
    a_exc: assert property (p_exc) else $error("exception");
    property p_dim; tk && op != 6'h3a |=> o_result_valid && o_dest_index == $past(i_instr[26:22]); endproperty
    a_dim: assert property (p_dim) else $error("imm dest");
    property p_drg; tk && op == 6'h3a |=> o_dest_index == $past(i_instr[21:17]); endproperty
    a_drg: assert property (p_drg) else $error("reg dest");
endmodule
bind greater_equal_compare_unit ge_unit_checker u_chk (.*);

// [tb/core_feed.sv]
`timescale 1ns/10ps
module core_feed (
    input wire logic i_clk,
    output logic o_valid,
    output logic [31:0] o_instr,
    output logic [31:0] o_first,
    output logic [31:0] o_second
);
    initial begin
        o_valid = 1'h0;
        o_instr = 32'h0;
        o_first = 32'h0;
        o_second = 32'h0;
    end
    task send(input logic [31:0] x, input logic [31:0] p, input logic [31:0] q);
        @(posedge i_clk);
        #1;
        o_valid = 1'h1;
        o_instr = x;
        o_first = p;
        o_second = q;
    endtask
    // Idle lines change so stale values never pass
    task idle();
        @(posedge i_clk);
        #1;
        o_valid = 1'h0;
        o_instr = ~o_instr;
        o_first = ~o_first;
        o_second = ~o_second;
    endtask
endmodule

// [tb/test_greater_equal_compare_unit.sv]
`timescale 1ns/10ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_total++; $display("CHECK FAILED %0t mismatch", $time); end end
module test_greater_equal_compare_unit;
    logic i_clk = 1'h0;
    logic i_reset_n = 1'h0;
    wire v, acc, rv, exc;
    wire [31:0] w, a, b, res;
    wire [4:0] dst;
    int err_total = 0;
    int comparisons = 0;
    logic [31:0] s = 32'h55;
    logic [37:0] e;
    logic [37:0] pe = '0;
    logic [36:0] held = '0;
    greater_equal_compare_unit DUT (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_valid(v), .i_instr(w),
        .i_first_operand(a), .i_second_operand(b), .o_accept(acc), .o_result_valid(rv),
        .o_result(res), .o_dest_index(dst), .o_exception(exc));
    core_feed u_core (.i_clk(i_clk), .o_valid(v), .o_instr(w), .o_first(a), .o_second(b));
    function automatic logic [31:0] xs();
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    function automatic logic [37:0] model(logic [31:0] x, logic [31:0] p, logic [31:0] q);
        logic [5:0] op;
        logic ge;
        op = x[5:0];
        ge = op == 6'h08 ? $signed(p) >= $signed({{16{x[21]}}, x[21:6]}) : op == 6'h28 ? p >= {16'h0, x[21:6]} : p >= q;
        return {op == 6'h08 || op == 6'h28 || (op == 6'h3a && x[16:6] == 11'h500),
            op == 6'h3a ? x[21:17] : x[26:22], 31'h0, ge};
    endfunction
    task stop_test();
        if (err_total == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        forever #10 i_clk = ~i_clk;
    end
    always @(negedge i_clk) if (i_reset_n) begin
        e = model(w, a, b);
        `CHK(acc, v && e[37])
        `CHK(exc, 1'h0)
        `CHK(rv, pe[37])
        if (pe[37]) `CHK({dst, res}, pe[36:0])
        else `CHK({dst, res}, held)
        if (pe[37]) held = pe[36:0];
        pe = {v && e[37], e[36:0]};
    end else begin
        `CHK(rv, 1'h0)
        `CHK({dst, res}, 37'h0)
        held = '0;
        pe = '0;
    end
    initial begin
        #30000;
        err_total++;
        stop_test();
    end
    initial begin
        logic [31:0] x, p;
        logic [5:0] op;
        repeat (3) @(posedge i_clk);
        #1 i_reset_n = 1'h1;
        for (int i = 0; i < 600; i++) begin
            x = xs();
            op = i % 5 == 0 ? x[5:0] : i % 5 == 1 ? 6'h08 : i % 5 == 2 ? 6'h28 : 6'h3a;
            x[5:0] = op;
            if (op == 6'h3a && i % 10 != 3) x[16:6] = 11'h500;
            p = xs();
            // Equal operands hit the >= boundary
            if (i % 4 == 0) p = op == 6'h08 ? {{16{x[21]}}, x[21:6]} : op == 6'h28 ? {16'h0, x[21:6]} : p;
            if (x[30:28] == 3'h0) u_core.idle();
            else u_core.send(x, p, i % 4 == 0 ? p : xs());
        end
        u_core.idle();
        // Reset in mid-run clears the result stage
        @(posedge i_clk);
        #1 i_reset_n = 1'h0;
        repeat (2) @(posedge i_clk);
        #1 i_reset_n = 1'h1;
        // Sign, zero-extension and unsigned corners
        u_core.send({10'h041, 16'h7fff, 6'h08}, 32'h8000_0000, 32'h0);
        u_core.send({10'h041, 16'hffff, 6'h08}, 32'hffff_ffff, 32'h0);
        u_core.send({10'h041, 16'h8000, 6'h08}, 32'hffff_7fff, 32'h0);
        u_core.send({10'h041, 16'hffff, 6'h28}, 32'h0000_fffe, 32'h0);
        u_core.send({10'h041, 16'hffff, 6'h28}, 32'h8000_0000, 32'h0);
        u_core.send({15'h0443, 6'h28, 5'h00, 6'h3a}, 32'h8000_0000, 32'h7fff_ffff);
        u_core.send({15'h0443, 6'h28, 5'h00, 6'h3a}, 32'h0, 32'hffff_ffff);
        u_core.send({15'h0443, 6'h28, 5'h01, 6'h3a}, 32'h1, 32'h0);
        u_core.send({15'h0443, 6'h20, 5'h00, 6'h3a}, 32'h1, 32'h0);
        u_core.idle();
        repeat (2) @(posedge i_clk);
        stop_test();
    end
endmodule
